// ### pkg/ntc_pkg.sv
// Constants, register map and state type of the thermistor measurement block
package ntc_pkg;
   localparam int CH_N = 5;
   localparam int NW = 10;
   localparam int IW = 2;
   localparam int EVW = 3;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PDSEL = 8'h04;
   localparam logic [7:0] A_THR = 8'h08;
   localparam logic [7:0] A_RES0 = 8'h0C;
   localparam logic [7:0] A_FAULT = 8'h20;
   localparam logic [7:0] A_GDIAG = 8'h24;
   localparam logic [7:0] A_ITEMP = 8'h28;
   localparam logic [7:0] A_DRES = 8'h2C;
   localparam logic [7:0] A_IRQST = 8'h30;
   localparam logic [7:0] A_IRQMSK = 8'h34;
   // Field positions
   localparam int F_DIAG_EN = 5;
   localparam int F_OTIDX = 10;
   localparam int F_RIDX = 10;
   localparam int F_RPD = 12;
   localparam int F_RVAL = 13;
   localparam int F_SHORT = 5;
   localparam int F_OPEN = 10;
   localparam int EV_RES = 0;
   localparam int EV_FLT = 1;
   localparam int EV_DIAG = 2;
   // Code thresholds
   localparam logic [NW-1:0] OVF_TH = 10'h3E8;
   localparam logic [NW-1:0] UNF_TH = 10'h0C8;
   localparam logic [NW-1:0] OPEN_TH = 10'h3FF;
   localparam logic [NW-1:0] SHORT_TH = 10'h040;
   localparam logic [NW-1:0] THR_RST = 10'h0C8;
   // Source indexes: 0=320uA, 1=80uA, 2=20uA, 3=5uA
   localparam logic [IW-1:0] IDX_LARGE = 2'h0;
   localparam logic [IW-1:0] IDX_SMALL = 2'h3;
   localparam logic [IW-1:0] IDX_DIAG = 2'h2;
   localparam logic [IW-1:0] OTIDX_RST = 2'h0;
   localparam logic [2:0] ADC_CH_DIAG = 3'h5;
   localparam logic [1:0] MAX_PER_RR = 2'h2;
   localparam logic [CH_N-1:0] CHEN_RST = 5'h1F;
   // Internal sensor: deg C = 547.3 - code * lsb; higher code is colder
   localparam real ITEMP_OFFSET_C = 547.3;
   typedef enum logic [2:0] {ST_IDLE, ST_PICK, ST_CONV, ST_DIAG} state_type;
endpackage

// ### verilog/ntc_temperature_measurement.sv
// Thermistor bias, source selection, results and fault flags with a Wishbone slave
// Operation
// - five thermistor channels, shared converter in turn
// - bias selected channel, then convert its voltage
// - pick best of four sources automatically
// - at most two measurements per round robin
// - collision delay switches bias sources off
// - store 2-bit source index with result
// - pull-down closed on selected thermistor inputs
// - result shows pull-down was active
// - valid set on store, cleared on read
// - open at 1023 smallest, short at 64 largest
// - per-channel overtemp, short, open flags
// - any fault sets summary bit
// - writing zero clears summary and fault flags
// - threshold and comparison source are configurable
// - diag resistor uses channel 0 source 2
// - store internal temperature code
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ntc_temperature_measurement import ntc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Round robin scheduler
   input wire logic rr_start,
   input wire logic rr_collision,
   input wire logic aux_manual_start,
   // Shared converter
   output logic adc_req,
   output logic [2:0] adc_chan,
   input wire logic adc_done,
   input wire logic [NW-1:0] adc_result,
   input wire logic int_temp_done,
   input wire logic [NW-1:0] int_temp_code,
   // Analog controls
   output logic [CH_N-1:0] bias_enable,
   output logic [IW-1:0] bias_source_index,
   output logic [CH_N-1:0] pulldown_enable,
   // Interrupt
   output logic irq
);
   state_type state_r;
   logic [2:0] cur_r, ptr_r;
   logic [1:0] meas_cnt_r;
   logic [CH_N-1:0] chan_en_r;
   logic diag_en_r;
   logic [CH_N-1:0] pd_sel_r;
   logic [NW-1:0] thr_r;
   logic [IW-1:0] ot_idx_r;
   logic [NW-1:0] res_code_r [CH_N];
   logic [IW-1:0] res_idx_r [CH_N];
   logic [IW-1:0] src_r [CH_N];
   logic [CH_N-1:0] res_pd_r, valid_r;
   logic [CH_N-1:0] ot_f_r, sh_f_r, op_f_r;
   logic summary_r;
   logic [NW-1:0] int_temp_r, diag_res_r;
   logic [EVW-1:0] irq_st_r, irq_mask_r;
   logic acc, wr, rd;
   logic [31:0] wm, rd_val;
   logic [2:0] rch;
   logic meas_done, diag_done;
   logic is_open, is_short, is_ot;
   logic [CH_N-1:0] cur_oh;
   logic [2:0] nxt_ch;
   logic sum_clr;
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[i*8 +: 8] = 8'hFF;
         end
      end
      return m;
   endfunction
   // Channel of a result register, or CH_N when the address is not one
   function automatic logic [2:0] res_chan(input logic [7:0] a);
      logic [2:0] c;
      c = 3'(CH_N);
      for (int i = 0; i < CH_N; i++) begin
         if (a == A_RES0 + 8'(4 * i)) begin
            c = 3'(i);
         end
      end
      return c;
   endfunction
   // Next enabled channel after the pointer, wrapping
   function automatic logic [2:0] next_chan(input logic [CH_N-1:0] en, input logic [2:0] p);
      logic [2:0] c;
      logic hit;
      int k;
      c = p;
      hit = 1'b0;
      for (int i = 1; i <= CH_N; i++) begin
         k = (int'(p) + i) % CH_N;
         if (!hit && en[k]) begin
            c = 3'(k);
            hit = 1'b1;
         end
      end
      return c;
   endfunction
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = acc && wb_we_i;
   assign rd = acc && !wb_we_i;
   assign wm = lane_mask(wb_sel_i);
   assign rch = res_chan(wb_adr_i);
   assign nxt_ch = next_chan(chan_en_r, ptr_r);
   assign cur_oh = CH_N'(1) << cur_r;
   assign meas_done = (state_r == ST_CONV) && adc_done && !rr_collision;
   assign diag_done = (state_r == ST_DIAG) && adc_done && !rr_collision;
   assign is_open = (adc_result >= OPEN_TH) && (bias_source_index == IDX_SMALL);
   assign is_short = (adc_result <= SHORT_TH) && (bias_source_index == IDX_LARGE);
   // Low voltage at the comparison current means low resistance, so hot
   assign is_ot = (bias_source_index == ot_idx_r) && (adc_result < thr_r) && !is_short;
   assign sum_clr = wr && (wb_adr_i == A_GDIAG) && wm[0] && !wb_dat_i[0];

   always_comb begin
      rd_val = '0;
      if (wb_adr_i == A_CTRL) begin
         rd_val[CH_N-1:0] = chan_en_r;
         rd_val[F_DIAG_EN] = diag_en_r;
      end else if (wb_adr_i == A_PDSEL) begin
         rd_val[CH_N-1:0] = pd_sel_r;
      end else if (wb_adr_i == A_THR) begin
         rd_val[NW-1:0] = thr_r;
         rd_val[F_OTIDX +: IW] = ot_idx_r;
      end else if (rch != 3'(CH_N)) begin
         rd_val[NW-1:0] = res_code_r[rch];
         rd_val[F_RIDX +: IW] = res_idx_r[rch];
         rd_val[F_RPD] = res_pd_r[rch];
         rd_val[F_RVAL] = valid_r[rch];
      end else if (wb_adr_i == A_FAULT) begin
         rd_val[CH_N-1:0] = ot_f_r;
         rd_val[F_SHORT +: CH_N] = sh_f_r;
         rd_val[F_OPEN +: CH_N] = op_f_r;
      end else if (wb_adr_i == A_GDIAG) begin
         rd_val[0] = summary_r;
      end else if (wb_adr_i == A_ITEMP) begin
         rd_val[NW-1:0] = int_temp_r;
      end else if (wb_adr_i == A_DRES) begin
         rd_val[NW-1:0] = diag_res_r;
      end else if (wb_adr_i == A_IRQST) begin
         rd_val[EVW-1:0] = irq_st_r;
      end else if (wb_adr_i == A_IRQMSK) begin
         rd_val[EVW-1:0] = irq_mask_r;
      end
   end

   // Bus answer: ack one cycle after the request, unmapped reads return zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= acc;
         if (rd) begin
            wb_dat_o <= rd_val;
         end
      end
   end

   // Software configuration
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_en_r <= CHEN_RST;
         diag_en_r <= 1'b0;
         pd_sel_r <= '0;
         thr_r <= THR_RST;
         ot_idx_r <= OTIDX_RST;
         irq_mask_r <= '0;
      end else if (wr) begin
         if (wb_adr_i == A_CTRL) begin
            chan_en_r <= (chan_en_r & ~wm[CH_N-1:0]) | (wb_dat_i[CH_N-1:0] & wm[CH_N-1:0]);
            if (wm[F_DIAG_EN]) begin
               diag_en_r <= wb_dat_i[F_DIAG_EN];
            end
         end else if (wb_adr_i == A_PDSEL) begin
            pd_sel_r <= (pd_sel_r & ~wm[CH_N-1:0]) | (wb_dat_i[CH_N-1:0] & wm[CH_N-1:0]);
         end else if (wb_adr_i == A_THR) begin
            thr_r <= (thr_r & ~wm[NW-1:0]) | (wb_dat_i[NW-1:0] & wm[NW-1:0]);
            if (wm[F_OTIDX]) begin
               ot_idx_r <= wb_dat_i[F_OTIDX +: IW];
            end
         end else if (wb_adr_i == A_IRQMSK) begin
            irq_mask_r <= (irq_mask_r & ~wm[EVW-1:0]) | (wb_dat_i[EVW-1:0] & wm[EVW-1:0]);
         end
      end
   end

   // Sequencer: a collision in any state but ST_IDLE aborts and drops the bias at once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         cur_r <= '0;
         ptr_r <= 3'(CH_N - 1);
         meas_cnt_r <= '0;
         adc_req <= 1'b0;
         adc_chan <= '0;
         bias_enable <= '0;
         bias_source_index <= IDX_LARGE;
      end else if (rr_collision && state_r != ST_IDLE) begin
         state_r <= ST_IDLE;
         bias_enable <= '0;
         adc_req <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (aux_manual_start && diag_en_r) begin
                  state_r <= ST_DIAG;
                  adc_req <= 1'b1;
                  adc_chan <= ADC_CH_DIAG;
                  bias_enable <= CH_N'(1);
                  bias_source_index <= IDX_DIAG;
               end else if (rr_start) begin
                  state_r <= ST_PICK;
                  meas_cnt_r <= '0;
               end
            end
            ST_PICK: begin
               if (meas_cnt_r == MAX_PER_RR || chan_en_r == '0) begin
                  state_r <= ST_IDLE;
               end else begin
                  state_r <= ST_CONV;
                  cur_r <= nxt_ch;
                  ptr_r <= nxt_ch;
                  meas_cnt_r <= meas_cnt_r + 2'h1;
                  adc_req <= 1'b1;
                  adc_chan <= nxt_ch;
                  bias_enable <= CH_N'(1) << nxt_ch;
                  bias_source_index <= src_r[nxt_ch];
               end
            end
            ST_CONV: begin
               if (adc_done) begin
                  state_r <= ST_PICK;
                  adc_req <= 1'b0;
                  bias_enable <= '0;
               end
            end
            ST_DIAG: begin
               if (adc_done) begin
                  state_r <= ST_IDLE;
                  adc_req <= 1'b0;
                  bias_enable <= '0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Per-channel result, valid flag and source choice
   for (genvar g = 0; g < CH_N; g++) begin : g_ch
      logic store;
      logic rd_clr;
      assign store = meas_done && (cur_r == 3'(g));
      assign rd_clr = rd && (rch == 3'(g));
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            res_code_r[g] <= '0;
            res_idx_r[g] <= IDX_LARGE;
            res_pd_r[g] <= 1'b0;
            src_r[g] <= IDX_LARGE;
         end else if (store) begin
            res_code_r[g] <= adc_result;
            res_idx_r[g] <= bias_source_index;
            res_pd_r[g] <= pulldown_enable[g];
            if (adc_result > OVF_TH && src_r[g] != IDX_SMALL) begin
               src_r[g] <= src_r[g] + 2'h1;
            end else if (adc_result < UNF_TH && src_r[g] != IDX_LARGE) begin
               src_r[g] <= src_r[g] - 2'h1;
            end
         end
      end
      // A store in the same cycle as the read keeps the flag set
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            valid_r[g] <= 1'b0;
         end else if (store) begin
            valid_r[g] <= 1'b1;
         end else if (rd_clr) begin
            valid_r[g] <= 1'b0;
         end
      end
   end

   // Fault flags and summary; a new fault outranks the software clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ot_f_r <= '0;
         sh_f_r <= '0;
         op_f_r <= '0;
         summary_r <= 1'b0;
      end else begin
         ot_f_r <= (sum_clr ? '0 : ot_f_r) | (meas_done && is_ot ? cur_oh : '0);
         sh_f_r <= (sum_clr ? '0 : sh_f_r) | (meas_done && is_short ? cur_oh : '0);
         op_f_r <= (sum_clr ? '0 : op_f_r) | (meas_done && is_open ? cur_oh : '0);
         if (meas_done && (is_ot || is_short || is_open)) begin
            summary_r <= 1'b1;
         end else if (sum_clr) begin
            summary_r <= 1'b0;
         end
      end
   end

   // Internal temperature and diagnosis resistor codes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_temp_r <= '0;
         diag_res_r <= '0;
      end else begin
         if (int_temp_done) begin
            int_temp_r <= int_temp_code;
         end
         if (diag_done) begin
            diag_res_r <= adc_result;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pulldown_enable <= '0;
      end else begin
         pulldown_enable <= pd_sel_r;
      end
   end

   // Sticky events, cleared by reading the status register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_st_r <= '0;
         irq <= 1'b0;
      end else begin
         irq_st_r[EV_RES] <= meas_done || (irq_st_r[EV_RES] && !(rd && wb_adr_i == A_IRQST));
         irq_st_r[EV_FLT] <= (meas_done && (is_ot || is_short || is_open))
                             || (irq_st_r[EV_FLT] && !(rd && wb_adr_i == A_IRQST));
         irq_st_r[EV_DIAG] <= diag_done || (irq_st_r[EV_DIAG] && !(rd && wb_adr_i == A_IRQST));
         irq <= |(irq_st_r & irq_mask_r);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_BIAS_OFF_COLLISION: assert property (
      rr_collision && state_r != ST_IDLE |=> bias_enable == '0 && state_r == ST_IDLE)
      else $error("bias stayed on after collision");
   AST_TWO_PER_RR: assert property (
      meas_cnt_r <= MAX_PER_RR)
      else $error("more than two measurements in one round robin");
   AST_ONE_HOT_BIAS: assert property (
      state_r == ST_CONV |-> bias_enable == cur_oh && adc_req && adc_chan == cur_r)
      else $error("bias does not match converted channel");
   AST_OPEN_FLAG: assert property (
      meas_done && adc_result >= OPEN_TH && bias_source_index == IDX_SMALL
      |=> op_f_r[$past(cur_r)] && summary_r)
      else $error("open fault not flagged");
   AST_SHORT_FLAG: assert property (
      meas_done && adc_result <= SHORT_TH && bias_source_index == IDX_LARGE
      |=> sh_f_r[$past(cur_r)])
      else $error("short fault not flagged");
   AST_SUMMARY: assert property (
      (ot_f_r | sh_f_r | op_f_r) != '0 |-> summary_r)
      else $error("fault flag without summary");
   AST_CLEAR: assert property (
      sum_clr && !meas_done |=> !summary_r && ot_f_r == '0 && sh_f_r == '0 && op_f_r == '0)
      else $error("summary clear did not reset fault flags");
   AST_VALID_SET: assert property (
      meas_done |=> valid_r[$past(cur_r)] ##1 res_code_r[$past(cur_r, 2)] == $past(adc_result, 2))
      else $error("result not stored with valid flag");
   AST_SRC_STEP_DOWN: assert property (
      meas_done && adc_result > OVF_TH && bias_source_index == src_r[cur_r]
      && src_r[cur_r] != IDX_SMALL |=> src_r[$past(cur_r)] == $past(bias_source_index) + 2'h1)
      else $error("source not stepped on overflow");
   AST_DIAG_SRC: assert property (
      state_r == ST_DIAG |-> bias_source_index == IDX_DIAG && bias_enable == CH_N'(1))
      else $error("diagnosis uses wrong source");
   AST_PULLDOWN: assert property (
      ##1 pulldown_enable == $past(pd_sel_r))
      else $error("pull-down does not follow select");
endmodule // ntc_temperature_measurement
`default_nettype wire

// ### tb/ntc_far_side.sv
// Behavioural converter and thermistor network answering the measurement block
`timescale 1ns/1ns
`default_nettype none
module ntc_far_side import ntc_pkg::*; #(
   parameter logic [NW-1:0] DIAG_CODE = 10'h155
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Requests from the block
   input wire logic adc_req,
   input wire logic [2:0] adc_chan,
   input wire logic [CH_N-1:0] bias_enable,
   input wire logic [IW-1:0] bias_source_index,
   input wire logic [CH_N-1:0] pulldown_enable,
   // Scenario settings: code each channel gives at the largest source, and latency
   input wire logic [CH_N-1:0][15:0] level,
   input wire logic [3:0] lat,
   // Answer
   output logic adc_done,
   output logic [NW-1:0] adc_result
);
   logic [3:0] cnt_r;
   logic [31:0] volt;
   logic [NW-1:0] code;
   always_comb begin
      volt = 32'h0000_0000;
      if (adc_chan == ADC_CH_DIAG && bias_enable[0]) begin
         volt = 32'(DIAG_CODE);
      end else if (adc_chan < 3'h5) begin
         // No bias or a closed pull-down leaves the input at ground
         if (bias_enable[adc_chan] && !pulldown_enable[adc_chan]) begin
            volt = 32'(level[adc_chan]) >> (2 * bias_source_index);
         end
      end
      code = (volt > 32'h0000_03FF) ? 10'h3FF : volt[NW-1:0];
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 4'h0;
         adc_done <= 1'b0;
         adc_result <= 10'h000;
      end else begin
         adc_done <= 1'b0;
         if (adc_req && !adc_done) begin
            if (cnt_r == lat) begin
               adc_done <= 1'b1;
               adc_result <= code;
               cnt_r <= 4'h0;
            end else begin
               cnt_r <= cnt_r + 4'h1;
            end
         end else begin
            // Result lines are meaningless outside the done pulse
            cnt_r <= 4'h0;
            adc_result <= ~adc_result;
         end
      end
   end
endmodule // ntc_far_side
`default_nettype wire

// ### tb/ntc_temperature_measurement_tb.sv
// Self-checking bench for the thermistor measurement block
`timescale 1ns/1ns
`default_nettype none
module ntc_temperature_measurement_tb import ntc_pkg::*;;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack;
   logic rr_start = 1'b0;
   logic rr_coll = 1'b0;
   logic aux_start = 1'b0;
   logic adc_req;
   logic [2:0] adc_chan;
   logic adc_done;
   logic [NW-1:0] adc_result;
   logic itemp_done = 1'b0;
   logic [NW-1:0] itemp_code = 10'h000;
   logic [CH_N-1:0] bias_en;
   logic [IW-1:0] bias_idx;
   logic [CH_N-1:0] pd_en;
   logic irq;
   logic [CH_N-1:0][15:0] level;
   logic [3:0] lat = 4'h3;
   logic [31:0] q;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   int ptr = 0;

   always #4 clk = ~clk;

   ntc_temperature_measurement ntc_temperature_measurement_i (.clk(clk), .rst_b(rst_b),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rr_start(rr_start),
      .rr_collision(rr_coll), .aux_manual_start(aux_start), .adc_req(adc_req),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_result(adc_result),
      .int_temp_done(itemp_done), .int_temp_code(itemp_code), .bias_enable(bias_en),
      .bias_source_index(bias_idx), .pulldown_enable(pd_en), .irq(irq));
   ntc_far_side ntc_far_side_i (.clk(clk), .rst_b(rst_b), .adc_req(adc_req),
      .adc_chan(adc_chan), .bias_enable(bias_en), .bias_source_index(bias_idx),
      .pulldown_enable(pd_en), .level(level), .lat(lat), .adc_done(adc_done),
      .adc_result(adc_result));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results;
      if (fails == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end

   // Classic single cycle; values seen right after an edge are those sampled at it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      // Ack ends this wait; only the bench timeout ends it if ack never comes
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(name, q, e);
   endtask

   task automatic wait_req(input logic v);
      int n;
      n = 0;
      while (adc_req !== v && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk("adc_req_wait", adc_req, v);
   endtask

   task automatic pulse_start;
      @(posedge clk);
      rr_start <= 1'b1;
      @(posedge clk);
      rr_start <= 1'b0;
   endtask

   task automatic run_rr;
      logic extra;
      extra = 1'b0;
      pulse_start();
      repeat (2) begin
         wait_req(1'b1);
         chk("adc_chan", adc_chan, ptr);
         chk("bias_enable", bias_en, 32'h0000_0001 << ptr);
         ptr = (ptr + 1) % CH_N;
         wait_req(1'b0);
      end
      repeat (12) begin
         @(posedge clk);
         extra = extra | (adc_req === 1'b1);
      end
      chk("third_conv", extra, 1'b0);
   endtask

   task automatic t_reset;
      rd_chk("ctrl", A_CTRL, 32'h0000_001F);
      rd_chk("thr", A_THR, 32'h0000_00C8);
      rd_chk("res0", A_RES0, 32'h0000_0000);
      rd_chk("fault", A_FAULT, 32'h0000_0000);
      wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h3C, 32'h0000_0000);
   endtask

   // Ten rounds bring channel 4 to its fourth measurement, the first at the smallest source
   task automatic t_rounds;
      wb(1'b1, A_IRQMSK, 32'h0000_0007);
      repeat (10) run_rr();
      rd_chk("res2", A_RES0 + 8'h08, 32'h0000_27E8);
      rd_chk("res4", A_RES0 + 8'h10, 32'h0000_2FFF);
      rd_chk("res4_again", A_RES0 + 8'h10, 32'h0000_0FFF);
      rd_chk("res1", A_RES0 + 8'h04, 32'h0000_201E);
      rd_chk("fault", A_FAULT, 32'h0000_4048);
      rd_chk("gdiag", A_GDIAG, 32'h0000_0001);
      chk("irq_set", irq, 1'b1);
      rd_chk("irqst", A_IRQST, 32'h0000_0003);
      repeat (2) @(posedge clk);
      chk("irq_clr", irq, 1'b0);
      wb(1'b1, A_GDIAG, 32'h0000_0001);
      rd_chk("gdiag_one", A_GDIAG, 32'h0000_0001);
      wb(1'b1, A_GDIAG, 32'h0000_0000);
      rd_chk("fault_clr", A_FAULT, 32'h0000_0000);
      rd_chk("gdiag_clr", A_GDIAG, 32'h0000_0000);
   endtask

   task automatic t_config;
      lat <= 4'h0;
      wb(1'b1, A_THR, 32'h0000_04C8);
      wb(1'b1, A_PDSEL, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("pulldown", pd_en, 32'h0000_0001);
      repeat (3) run_rr();
      rd_chk("fault_cfg", A_FAULT, 32'h0000_4060);
      rd_chk("res0_pd", A_RES0, 32'h0000_3000);
      rd_chk("res2_src", A_RES0 + 8'h08, 32'h0000_27E8);
      rd_chk("res4_code", A_RES0 + 8'h10, 32'h0000_2FFF);
      wb(1'b1, A_PDSEL, 32'h0000_0000);
   endtask

   task automatic t_diag;
      wb(1'b1, A_IRQMSK, 32'h0000_0000);
      wb(1'b0, A_IRQST, 32'h0000_0000);
      wb(1'b1, A_CTRL, 32'h0000_003F);
      @(posedge clk);
      aux_start <= 1'b1;
      @(posedge clk);
      aux_start <= 1'b0;
      wait_req(1'b1);
      chk("diag_chan", adc_chan, ADC_CH_DIAG);
      chk("diag_bias", bias_en, 32'h0000_0001);
      chk("diag_idx", bias_idx, IDX_DIAG);
      wait_req(1'b0);
      rd_chk("dres", A_DRES, 32'h0000_0155);
      chk("irq_masked", irq, 1'b0);
      wb(1'b1, A_IRQMSK, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk("irq_diag", irq, 1'b1);
      rd_chk("irqst_diag", A_IRQST, 32'h0000_0004);
   endtask

   task automatic t_itemp;
      @(posedge clk);
      itemp_done <= 1'b1;
      itemp_code <= 10'h2AB;
      @(posedge clk);
      itemp_done <= 1'b0;
      rd_chk("itemp", A_ITEMP, 32'h0000_02AB);
   endtask

   // Slow converter so the collision lands mid-conversion
   task automatic t_collision;
      logic seen;
      seen = 1'b0;
      lat <= 4'hC;
      pulse_start();
      wait_req(1'b1);
      rr_coll <= 1'b1;
      @(posedge clk);
      rr_coll <= 1'b0;
      @(posedge clk);
      chk("coll_bias", bias_en, 32'h0000_0000);
      chk("coll_req", adc_req, 1'b0);
      repeat (30) begin
         @(posedge clk);
         seen = seen | (adc_req === 1'b1);
      end
      chk("coll_rest", seen, 1'b0);
   endtask

   initial begin
      level[0] = 16'h01F4;
      level[1] = 16'h001E;
      level[2] = 16'h0FA0;
      level[3] = 16'h0096;
      level[4] = 16'hFFC0;
      repeat (3) @(posedge clk);
      chk("rst_idx", bias_idx, IDX_LARGE);
      chk("rst_req", adc_req, 1'b0);
      rst_b <= 1'b1;
      t_reset();
      t_rounds();
      t_config();
      t_diag();
      t_itemp();
      t_collision();
      results();
   end
endmodule // ntc_temperature_measurement_tb
`default_nettype wire
